//--- bench/gate_driver_model.sv
// Gate driver stand-in that counts shoot-through seen on the six drive pins
`timescale 1ns/1ps
module gate_driver_model (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire excitation_pkg::drive_grp_type drive_out,
    input wire excitation_pkg::drive_grp_type inactive_level,
    output logic [15:0] shoot_count
);
    excitation_pkg::drive_grp_type inactive_level_ff;
    excitation_pkg::drive_grp_type on_now;
    logic armed_ff;
    // Pins are judged against the inactive level that was in force when they were launched
    assign on_now = drive_out ^ inactive_level_ff;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            inactive_level_ff <= excitation_pkg::GRP_IDLE;
            armed_ff <= 1'b0;
            shoot_count <= 16'h0000;
        end else begin
            inactive_level_ff <= inactive_level;
            armed_ff <= 1'b1;
            if (armed_ff && (|on_now.pos) && (|on_now.neg)) begin
                shoot_count <= shoot_count + 16'h0001;
            end
        end
    end
endmodule

//--- bench/special_excitation_pattern_select_tb_top.sv
// Self-checking bench of the excitation pattern selector with a cycle model
`timescale 1ns/1ps
module special_excitation_pattern_select_tb_top;
    typedef struct packed {
        excitation_pkg::drive_grp_type drv;
        logic [3:0] stat;
    } exp_result_type;
    localparam int CYCLE_LIMIT = 4000;
    logic clk_sys, reset_n, special_mode, sw_output_ctl_sel, trigger_switch_sel, cycle_end;
    logic [2:0] sw_phase_code, sensed_phase_flags, applied_code, cur_code;
    logic [3:0] compare_match, pwm_sig;
    logic [7:0] dead_time_pos, dead_time_neg, blk_pos_cnt, blk_neg_cnt, pat_lvl;
    logic [5:0] exp_act;
    logic code_moved, overlap_config;
    logic [15:0] shoot_count;
    excitation_pkg::pattern_words_type pattern_words;
    excitation_pkg::drive_grp_type inactive_level, drive_out;
    exp_result_type exp_q[$];
    exp_result_type cur_exp;
    logic [2:0] rot_seq [6] = '{3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};
    int rot_idx, err_count, checked, cycles;

    special_excitation_pattern_select #(.DT_W(8)) u_special_excitation_pattern_select (
        .clk_sys(clk_sys), .reset_n(reset_n), .special_mode(special_mode),
        .sw_output_ctl_sel(sw_output_ctl_sel), .trigger_switch_sel(trigger_switch_sel),
        .sw_phase_code(sw_phase_code), .sensed_phase_flags(sensed_phase_flags),
        .cycle_end(cycle_end), .compare_match(compare_match), .pattern_words(pattern_words),
        .pwm_sig(pwm_sig), .inactive_level(inactive_level), .dead_time_pos(dead_time_pos),
        .dead_time_neg(dead_time_neg), .drive_out(drive_out),
        .overlap_config(overlap_config), .applied_code(applied_code));
    gate_driver_model u_gate_driver_model (.clk_sys(clk_sys), .reset_n(reset_n),
        .drive_out(drive_out), .inactive_level(inactive_level), .shoot_count(shoot_count));

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sources per output o1,o3,o5,o2,o4,o6: 0-7 pattern, 8-b pwm 1-4, f inactive
    function automatic logic [23:0] src_tab(input logic [2:0] code, input logic spec);
        case (code)
            3'h5: return spec ? 24'h1f_3f64 : 24'h8f_ffbf;
            3'h4: return spec ? 24'h20_ff75 : 24'h9f_fffa;
            3'h6: return spec ? 24'h31_f4f6 : 24'hf8_fffb;
            3'h2: return spec ? 24'hf2_05f7 : 24'hf9_faff;
            3'h3: return spec ? 24'hf3_164f : 24'hff_8bff;
            3'h1: return spec ? 24'h0f_275f : 24'hff_9faf;
            default: return 24'hff_ffff;
        endcase
    endfunction

    // Advances the model by the coming clock edge and notes what the pins must show
    task automatic step();
        logic [5:0] r;
        logic [31:0] w;
        logic [3:0] f;
        logic pf, nf;
        int hb;
        w = pattern_words;
        for (int i = 0; i < 6; i++) begin
            f = 4'(src_tab(cur_code, special_mode) >> (20 - 4 * i));
            r[i] = (f == 4'hf) ? 1'b0 : (f < 4'h8) ? pat_lvl[f[2:0]] : pwm_sig[f[1:0]];
        end
        if (cur_code == 3'h7 || (cur_code == 3'h0 && code_moved)) r = exp_act;
        if ((|r[2:0]) && (|r[5:3])) begin
            if ((|exp_act[5:3]) && !(|exp_act[2:0])) r[2:0] = 3'h0;
            else r[5:3] = 3'h0;
        end
        pf = (|(exp_act[2:0] & ~r[2:0])) && (dead_time_pos != 8'h00);
        nf = (|(exp_act[5:3] & ~r[5:3])) && (dead_time_neg != 8'h00);
        if (pf || blk_neg_cnt != 8'h00) r[5:3] = 3'h0;
        if (nf || blk_pos_cnt != 8'h00) r[2:0] = 3'h0;
        blk_neg_cnt = pf ? dead_time_pos - 8'h01 : blk_neg_cnt - 8'(blk_neg_cnt != 8'h00);
        blk_pos_cnt = nf ? dead_time_neg - 8'h01 : blk_pos_cnt - 8'(blk_pos_cnt != 8'h00);
        exp_act = r;
        if (compare_match != 4'h0) begin
            for (int i = 0; i < 4; i++) if (compare_match[i]) hb = i;
            for (int k = 0; k < 8; k++) pat_lvl[k] = w[4 * k + hb];
        end
        code_moved = code_moved | (cur_code != 3'h0);
        if (cycle_end) begin
            cur_code = (sw_output_ctl_sel || trigger_switch_sel) ? sw_phase_code
                : sensed_phase_flags;
        end
        exp_q.push_back({r ^ inactive_level, ((w[3:0] != 4'h0) && (w[31:28] != 4'h0))
            || ((w[15:12] != 4'h0) && (w[19:16] != 4'h0)), cur_code});
    endtask

    task automatic tick();
        step();
        @(negedge clk_sys);
    endtask

    task automatic run(input int n, input logic spec, input logic olap, input logic rot);
        logic [31:0] w;
        for (int c = 0; c < n; c++) begin
            special_mode = spec;
            cycle_end = ($urandom % 4) == 0;
            if (cycle_end && rot) rot_idx = (rot_idx + 1) % 6;
            sw_phase_code = rot ? rot_seq[rot_idx] : 3'($urandom);
            sensed_phase_flags = rot ? rot_seq[rot_idx] : 3'($urandom);
            {sw_output_ctl_sel, trigger_switch_sel} = 2'($urandom);
            compare_match = ($urandom % 3 == 0) ? 4'($urandom) : 4'h0;
            pwm_sig = 4'($urandom);
            if (c % 64 == 0) inactive_level = 6'($urandom);
            if (c % 16 == 0) begin
                w = $urandom;
                // Patterns 3 and 7 kept idle so neither forbidden pair can be active
                if (!olap) w = w & 32'h0fff_0fff;
                pattern_words = w;
            end
            tick();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic cmp_drive(input excitation_pkg::drive_grp_type e,
        input excitation_pkg::drive_grp_type g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] t=%0t drive exp=%h got=%h", $time, e, g);
        end
    endtask

    task automatic cmp_val(input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] t=%0t value exp=%h got=%h", $time, e, g);
        end
    endtask

    task automatic end_of_test();
        if (err_count == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        #1;
        if (exp_q.size() > 0) begin
            cur_exp = exp_q.pop_front();
            cmp_drive(cur_exp.drv, drive_out);
            cmp_val({12'h000, cur_exp.stat}, {12'h000, overlap_config, applied_code});
        end
    end

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles >= CYCLE_LIMIT) begin
            err_count++;
            end_of_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(95164));
        {reset_n, special_mode, sw_output_ctl_sel, trigger_switch_sel, cycle_end} = 5'h00;
        {sw_phase_code, sensed_phase_flags, compare_match, pwm_sig} = 14'h0000;
        {dead_time_pos, dead_time_neg, pat_lvl, blk_pos_cnt, blk_neg_cnt} = 40'h00_0000_0000;
        {exp_act, cur_code, code_moved} = 10'h000;
        pattern_words = 32'h0000_0000;
        inactive_level = 6'($urandom);
        repeat (16) @(negedge clk_sys);
        reset_n = 1'b1;
        repeat (4) tick();
        run(300, 1'b0, 1'b0, 1'b1);
        run(300, 1'b1, 1'b0, 1'b1);
        run(300, 1'b1, 1'b1, 1'b0);
        run(200, 1'b0, 1'b0, 1'b0);
        // Ordinary mode code 101 hands the bridge between outputs 4 and 1 across dead time
        {special_mode, sw_output_ctl_sel, trigger_switch_sel, cycle_end, compare_match} = 8'h70;
        {sw_phase_code, pwm_sig, dead_time_pos, dead_time_neg} = 23'h50_0302;
        tick();
        cycle_end = 1'b0;
        repeat (3) tick();
        pwm_sig = 4'h8;
        repeat (6) tick();
        pwm_sig = 4'h1;
        repeat (6) tick();
        pwm_sig = 4'h8;
        repeat (6) tick();
        @(posedge clk_sys);
        #2;
        cmp_val(16'h0000, shoot_count);
        end_of_test();
    end
endmodule

//--- design/special_excitation_pattern_select.sv
// Phase-code driven selection of six drive outputs with overlap protection
`timescale 1ns/1ps
module special_excitation_pattern_select #(
    parameter int DT_W = 8
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic special_mode,
    input wire logic sw_output_ctl_sel,
    input wire logic trigger_switch_sel,
    input wire logic [2:0] sw_phase_code,
    input wire logic [2:0] sensed_phase_flags,
    input wire logic cycle_end,
    input wire logic [excitation_pkg::CMP_N-1:0] compare_match,
    input wire excitation_pkg::pattern_words_type pattern_words,
    input wire logic [excitation_pkg::PWM_N-1:0] pwm_sig,
    input wire excitation_pkg::drive_grp_type inactive_level,
    input wire logic [DT_W-1:0] dead_time_pos,
    input wire logic [DT_W-1:0] dead_time_neg,
    output excitation_pkg::drive_grp_type drive_out,
    output logic overlap_config,
    output logic [2:0] applied_code
);

    generate
        if (DT_W < 1 || DT_W > 16) begin : g_bad_width
            $error("DT_W must lie between 1 and 16");
        end
    endgenerate

    typedef struct packed {
        logic [2:0] code;
        logic moved;
        excitation_pkg::owner_type owner;
        excitation_pkg::drive_grp_type act;
        logic [DT_W-1:0] dt_pos_cnt;
        logic [DT_W-1:0] dt_neg_cnt;
        excitation_pkg::drive_grp_type drive;
        logic overlap;
    } sel_state_type;

    sel_state_type st_ff;
    sel_state_type nxt_st;
    logic [excitation_pkg::PAT_N-1:0] sp;
    logic [2:0] sel_code;
    excitation_pkg::drive_grp_type req;
    excitation_pkg::drive_grp_type req_raw;
    logic hold;
    logic blank;
    logic both_req;
    logic pos_fall;
    logic neg_fall;
    logic overlap_cond;

    ////////////////////////////////////////////////////////////////////////////////
    special_pattern_gen u_pattern_gen (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .pattern_words(pattern_words),
        .compare_match(compare_match),
        .pattern_level(sp)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Code order 101,100,110,010,011,001 walks sixty degrees per step
    function automatic excitation_pkg::drive_grp_type map_code(
        input logic [2:0] code,
        input logic spec,
        input logic [excitation_pkg::PAT_N-1:0] p,
        input logic [excitation_pkg::PWM_N-1:0] w
    );
        excitation_pkg::drive_grp_type g;
        g = excitation_pkg::GRP_IDLE;
        if (spec) begin
            case (code)
                excitation_pkg::PH_101: begin
                    g.pos = {p[3], 1'b0, p[1]};
                    g.neg = {p[4], p[6], 1'b0};
                end
                excitation_pkg::PH_100: begin
                    g.pos = {1'b0, p[0], p[2]};
                    g.neg = {p[5], p[7], 1'b0};
                end
                excitation_pkg::PH_110: begin
                    g.pos = {1'b0, p[1], p[3]};
                    g.neg = {p[6], 1'b0, p[4]};
                end
                excitation_pkg::PH_010: begin
                    g.pos = {p[0], p[2], 1'b0};
                    g.neg = {p[7], 1'b0, p[5]};
                end
                excitation_pkg::PH_011: begin
                    g.pos = {p[1], p[3], 1'b0};
                    g.neg = {1'b0, p[4], p[6]};
                end
                excitation_pkg::PH_001: begin
                    g.pos = {p[2], 1'b0, p[0]};
                    g.neg = {1'b0, p[5], p[7]};
                end
                default: begin
                    g = excitation_pkg::GRP_IDLE;
                end
            endcase
        end else begin
            case (code)
                excitation_pkg::PH_101: begin
                    g.pos = {1'b0, 1'b0, w[0]};
                    g.neg = {1'b0, w[3], 1'b0};
                end
                excitation_pkg::PH_100: begin
                    g.pos = {1'b0, 1'b0, w[1]};
                    g.neg = {w[2], 1'b0, 1'b0};
                end
                excitation_pkg::PH_110: begin
                    g.pos = {1'b0, w[0], 1'b0};
                    g.neg = {w[3], 1'b0, 1'b0};
                end
                excitation_pkg::PH_010: begin
                    g.pos = {1'b0, w[1], 1'b0};
                    g.neg = {1'b0, 1'b0, w[2]};
                end
                excitation_pkg::PH_011: begin
                    g.pos = {w[0], 1'b0, 1'b0};
                    g.neg = {1'b0, 1'b0, w[3]};
                end
                excitation_pkg::PH_001: begin
                    g.pos = {w[1], 1'b0, 1'b0};
                    g.neg = {1'b0, w[2], 1'b0};
                end
                default: begin
                    g = excitation_pkg::GRP_IDLE;
                end
            endcase
        end
        return g;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Software bits rule whenever software control or trigger switching is chosen
    assign sel_code = (sw_output_ctl_sel || trigger_switch_sel) ?
        sw_phase_code : sensed_phase_flags;

    assign overlap_cond =
        ((pattern_words.low[excitation_pkg::NIB_W-1:0] != excitation_pkg::NIB_ZERO) &&
         (pattern_words.high[excitation_pkg::LOW_NIB_HI:excitation_pkg::LOW_NIB_LO]
          != excitation_pkg::NIB_ZERO)) ||
        ((pattern_words.low[excitation_pkg::LOW_NIB_HI:excitation_pkg::LOW_NIB_LO]
          != excitation_pkg::NIB_ZERO) &&
         (pattern_words.high[excitation_pkg::NIB_W-1:0] != excitation_pkg::NIB_ZERO));

    always_comb begin
        nxt_st = st_ff;
        req_raw = map_code(st_ff.code, special_mode, sp, pwm_sig);
        hold = (st_ff.code == excitation_pkg::PH_111) ||
            ((st_ff.code == excitation_pkg::PH_000) && st_ff.moved);
        blank = (st_ff.code == excitation_pkg::PH_000) && !st_ff.moved;
        req = blank ? excitation_pkg::GRP_IDLE : req_raw;
        both_req = (|req.pos) && (|req.neg);
        pos_fall = 1'b0;
        neg_fall = 1'b0;

        // A code that arrives mid-cycle waits for the cycle end
        if (cycle_end) begin
            nxt_st.code = sel_code;
        end
        if (st_ff.code != excitation_pkg::PH_000) begin
            nxt_st.moved = 1'b1;
        end

        // The group that got there first keeps the bridge; a tie goes positive
        if (both_req) begin
            if (st_ff.owner == excitation_pkg::OWN_NEG) begin
                req.pos = 3'h0;
            end else begin
                req.neg = 3'h0;
            end
        end

        // Running dead time blocks the opposite group from turning on
        if (st_ff.dt_pos_cnt != '0) begin
            req.neg = 3'h0;
        end
        if (st_ff.dt_neg_cnt != '0) begin
            req.pos = 3'h0;
        end
        pos_fall = |(st_ff.act.pos & ~req.pos);
        neg_fall = |(st_ff.act.neg & ~req.neg);
        // The fall edge itself already counts as a dead cycle
        if (pos_fall && (dead_time_pos != '0)) begin
            req.neg = 3'h0;
        end
        if (neg_fall && (dead_time_neg != '0)) begin
            req.pos = 3'h0;
        end

        if (!hold) begin
            nxt_st.act = req;
        end
        if (!hold && pos_fall) begin
            nxt_st.dt_pos_cnt = dead_time_pos - DT_W'(1'b1);
        end else if (st_ff.dt_pos_cnt != '0) begin
            nxt_st.dt_pos_cnt = st_ff.dt_pos_cnt - DT_W'(1'b1);
        end
        if (!hold && neg_fall) begin
            nxt_st.dt_neg_cnt = dead_time_neg - DT_W'(1'b1);
        end else if (st_ff.dt_neg_cnt != '0) begin
            nxt_st.dt_neg_cnt = st_ff.dt_neg_cnt - DT_W'(1'b1);
        end
        if (!hold && pos_fall && (dead_time_pos == '0)) begin
            nxt_st.dt_pos_cnt = '0;
        end
        if (!hold && neg_fall && (dead_time_neg == '0)) begin
            nxt_st.dt_neg_cnt = '0;
        end

        if (|nxt_st.act.pos) begin
            nxt_st.owner = excitation_pkg::OWN_POS;
        end else if (|nxt_st.act.neg) begin
            nxt_st.owner = excitation_pkg::OWN_NEG;
        end else begin
            nxt_st.owner = excitation_pkg::OWN_NONE;
        end

        // Pin level is the inactive level, flipped while the output is active
        nxt_st.drive = nxt_st.act ^ inactive_level;
        nxt_st.overlap = overlap_cond;
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign drive_out = st_ff.drive;
    assign overlap_config = st_ff.overlap;
    assign applied_code = st_ff.code;

    ////////////////////////////////////////////////////////////////////////////////
    a_no_shoot_through: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !((|st_ff.act.pos) && (|st_ff.act.neg)))
        else $error("positive and negative outputs active together");

    a_overlap_flag: assert property (@(posedge clk_sys) disable iff (!reset_n)
        overlap_cond |=> overlap_config)
        else $error("overlap configuration not flagged");

    a_pos_keeps_bridge: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (st_ff.owner == excitation_pkg::OWN_POS && both_req && !hold)
        |=> (st_ff.act.neg == 3'h0))
        else $error("negative group took over from earlier positive group");

    a_neg_keeps_bridge: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (st_ff.owner == excitation_pkg::OWN_NEG && both_req && !hold)
        |=> (st_ff.act.pos == 3'h0))
        else $error("positive group took over from earlier negative group");

    a_tie_goes_pos: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (st_ff.owner == excitation_pkg::OWN_NONE && both_req && !hold
         && st_ff.dt_neg_cnt == '0 && st_ff.act == excitation_pkg::GRP_IDLE)
        |=> (st_ff.act.neg == 3'h0) && (|st_ff.act.pos))
        else $error("simultaneous start did not favour positive group");

    a_code_on_cycle: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !cycle_end |=> $stable(applied_code))
        else $error("phase code changed outside a cycle end");

    a_code_source: assert property (@(posedge clk_sys) disable iff (!reset_n)
        cycle_end |=> (applied_code == $past(sel_code)))
        else $error("cycle end did not take the selected phase code");

    a_idle_before_move: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (applied_code == excitation_pkg::PH_000 && !st_ff.moved)
        |=> (st_ff.act == excitation_pkg::GRP_IDLE))
        else $error("outputs active before the code ever moved");

    a_hold_on_all_ones: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (applied_code == excitation_pkg::PH_111) |=> $stable(st_ff.act))
        else $error("outputs changed while code 111 holds");

    a_inactive_level: assert property (@(posedge clk_sys) disable iff (!reset_n)
        1'b1 |=> (drive_out == (st_ff.act ^ $past(inactive_level))))
        else $error("drive pin does not follow inactive level");

    a_dead_pos: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (st_ff.dt_pos_cnt != '0) |=> (st_ff.act.neg == 3'h0))
        else $error("negative output rose inside positive dead time");

endmodule

//--- design/special_pattern_gen.sv
// Eight special pattern levels driven by compare matches and the pattern words
`timescale 1ns/1ps
module special_pattern_gen (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire excitation_pkg::pattern_words_type pattern_words,
    input wire logic [excitation_pkg::CMP_N-1:0] compare_match,
    output logic [excitation_pkg::PAT_N-1:0] pattern_level
);

    typedef struct packed {
        logic [excitation_pkg::PAT_N-1:0] lvl;
    } gen_state_type;

    gen_state_type st_ff;
    gen_state_type nxt_st;
    logic [excitation_pkg::PAT_N-1:0] nxt_lvl;
    logic [31:0] words_flat;

    assign words_flat = {pattern_words.high, pattern_words.low};

    ////////////////////////////////////////////////////////////////////////////////
    genvar k;
    generate
        for (k = 0; k < excitation_pkg::PAT_N; k++) begin : g_pat
            logic [excitation_pkg::NIB_W-1:0] nib;
            assign nib = words_flat[k*excitation_pkg::NIB_W +: excitation_pkg::NIB_W];
            // Highest matching compare decides the level; no match keeps it
            assign nxt_lvl[k] = compare_match[3] ? nib[3] :
                compare_match[2] ? nib[2] :
                compare_match[1] ? nib[1] :
                compare_match[0] ? nib[0] : st_ff.lvl[k];
        end
    endgenerate

    always_comb begin
        nxt_st = st_ff;
        nxt_st.lvl = nxt_lvl;
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign pattern_level = st_ff.lvl;

    a_tie_high_wins: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (compare_match[3] && compare_match[2]) |=> (pattern_level[0] == $past(words_flat[3])))
        else $error("compare 3 did not win a tie with compare 2");

endmodule

//--- inc/excitation_pkg.sv
// Shared constants and carrier types of the special excitation pattern selector
// Behaviour
// - Flag nonzero opposing nibbles as simultaneous activity
// - Never drive positive and negative together
// - Positive group first keeps positive during overlap
// - Negative group first keeps negative during overlap
// - Simultaneous start gives positive group priority
// - Special mode positive outputs use patterns 0-3
// - Ordinary mode uses pwm signals 1-4
// - Pwm signals 1-4 come from compares 1-4
// - Patterns come from compares 0-3 and words
// - Six codes step sixty degrees each
// - Ordinary mode odd outputs mapping per code
// - Ordinary mode even outputs mapping per code
// - Special mode widens range sixty degrees each way
// - Special mode odd outputs mapping per code
// - Special mode even outputs mapping per code
// - Code 000 idle until moved, then holds
// - Code 111 holds previous output levels
// - Inactive means configured inactive level
// - Code change applies from next pwm cycle
// - Dead time on each phase falling edge
// - Higher numbered compare match wins ties
package excitation_pkg;

    localparam logic [2:0] PH_000 = 3'h0;
    localparam logic [2:0] PH_001 = 3'h1;
    localparam logic [2:0] PH_010 = 3'h2;
    localparam logic [2:0] PH_011 = 3'h3;
    localparam logic [2:0] PH_100 = 3'h4;
    localparam logic [2:0] PH_101 = 3'h5;
    localparam logic [2:0] PH_110 = 3'h6;
    localparam logic [2:0] PH_111 = 3'h7;

    localparam int NIB_W = 4;
    localparam int PAT_N = 8;
    localparam int CMP_N = 4;
    localparam int PWM_N = 4;
    localparam int LOW_NIB_HI = 15;
    localparam int LOW_NIB_LO = 12;

    localparam logic [3:0] NIB_ZERO = 4'h0;
    localparam logic [15:0] WORD_ZERO = 16'h0000;

    typedef enum logic [1:0] {
        OWN_NONE = 2'b00,
        OWN_POS = 2'b01,
        OWN_NEG = 2'b10
    } owner_type;

    // pos bits 0..2 are outputs 1,3,5; neg bits 0..2 are outputs 2,4,6
    typedef struct packed {
        logic [2:0] neg;
        logic [2:0] pos;
    } drive_grp_type;

    typedef struct packed {
        logic [15:0] high;
        logic [15:0] low;
    } pattern_words_type;

    localparam drive_grp_type GRP_IDLE = '{neg: 3'h0, pos: 3'h0};

endpackage
